/* include/cscfg_regs.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef CSCFG_REGS_VH
`define CSCFG_REGS_VH
// ************************************************************
// Command codes of the two configuration words
// ************************************************************
`define CSCFG_CMD_ISENSE    8'hD0
`define CSCFG_CMD_MISC      8'hD1
// ************************************************************
// Current-sense configuration fields
// ************************************************************
`define CSCFG_BLANK_MSB     15
`define CSCFG_BLANK_LSB     11
`define CSCFG_FCNT_MSB      10
`define CSCFG_FCNT_LSB      8
`define CSCFG_METH_MSB      3
`define CSCFG_METH_LSB      2
`define CSCFG_RANGE_MSB     1
`define CSCFG_RANGE_LSB     0
`define CSCFG_METH_FALL     2'h1
`define CSCFG_METH_RISE     2'h2
`define CSCFG_RANGE_25MV    2'h0
`define CSCFG_RANGE_35MV    2'h1
`define CSCFG_RANGE_50MV    2'h2
// ************************************************************
// Misc device configuration fields
// ************************************************************
`define CSCFG_MIND_MSB      15
`define CSCFG_MIND_LSB      11
`define CSCFG_DRV_EN_BIT    10
`define CSCFG_MIND_EN_BIT   7
`define CSCFG_PGOOD_PP_BIT  2
`define CSCFG_EXT_COMP_BIT  1
`define CSCFG_EXT_FLT_BIT   0
// ************************************************************
// Reset values and timing
// ************************************************************
`define CSCFG_ISENSE_RST    16'h0000
`define CSCFG_MISC_RST      16'h0400
`define CSCFG_BLANK_STEP_NS 32
`define CSCFG_CLK_NS        50
`define CSCFG_MIND_DEN      512
`endif

/* verilog/cscfg_fault_qual.v */
// Consecutive over/under-current event qualifier, one event per switching cycle
`timescale 1ns/100ps
module cscfg_fault_qual #(
   parameter CW = 4                  // Counter width, holds up to 15
) (
   input  wire          clk,
   input  wire          rstn,
   input  wire          ce,
   input  wire          cyc_start,   // Pulse at the start of each switching cycle
   input  wire          evt,         // Event seen (any cycle of the period)
   input  wire [2:0]    fault_code,  // Count code, n selects 2n+1
   output reg           fault,       // Qualified current fault, level
   output wire [CW-1:0] run_count    // Current consecutive count
);
   // ************************************************************
   // Per-period latch and run counter
   // ************************************************************
   reg          seen_r;               // Event seen in current period
   reg [CW-1:0] cnt_r;                // Consecutive periods with events
   wire [CW-1:0] need = {fault_code, 1'b1}; // 2n+1
   wire         hit  = seen_r | evt;  // Event closing this period
   assign run_count = cnt_r;

   // Many events in a period collapse into one flag
   always @(posedge clk) begin
      if (!rstn) begin
         seen_r <= 1'b0;
         cnt_r  <= {CW{1'b0}};
         fault  <= 1'b0;
      end else if (ce) begin
         if (cyc_start) begin
            seen_r <= 1'b0;           // New period starts clean
            if (hit) begin
               // Saturate so a long fault holds
               if (cnt_r != {CW{1'b1}})
                  cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
               if (cnt_r + {{(CW-1){1'b0}}, 1'b1} >= need)
                  fault <= 1'b1;
            end else begin
               cnt_r <= {CW{1'b0}};
               fault <= 1'b0;
            end
         end else if (evt) begin
            seen_r <= 1'b1;
         end
      end
   end
endmodule // cscfg_fault_qual

/* verilog/cscfg_top.v */
// Current-sense and misc configuration decode for a point-of-load converter
`timescale 1ns/100ps
`include "cscfg_regs.vh"
module cscfg_top #(
   parameter PW = 16                  // Switching period count width in bits
) (
   input  wire          clk,
   input  wire          rstn,
   input  wire          ce,
   input  wire [7:0]    cmd_code,     // Management command code
   input  wire          wr_en,        // Word write strobe
   input  wire [15:0]   wr_data,      // Written word
   output reg  [15:0]   rd_data,      // Read word for cmd_code
   output wire          rd_valid,     // Code is mapped
   input  wire [PW-1:0] period_clks,  // Switching period in clocks
   input  wire          cyc_start,    // Switching cycle start, same domain
   input  wire          edge_evt,     // Switch transition pulse, same domain
   input  wire          oc_pin,       // Over-current comparator, async
   input  wire          uc_pin,       // Under-current comparator, async
   input  wire          power_good_level, // Internal power-good state
   input  wire          pwm_in,       // Raw modulator output
   output reg           meas_enable,  // Measurement window open
   output reg           sense_on_falling_ripple,
   output reg           sense_on_rising_ripple,
   output reg  [1:0]    adc_range_sel,
   output reg  [PW-1:0] min_on_clks,  // Minimum on time in clocks
   output reg           pwm_out,      // Gated power switch drive
   output reg           power_good_pin_o,
   output reg           power_good_pin_oe,
   output reg           ext_temp_comp_en,
   output reg           ext_temp_fault_sel,
   output reg           current_fault
);
   // ************************************************************
   // Registers
   // ************************************************************
   reg  [15:0] isense_r;              // Current-sense configuration
   reg  [15:0] misc_r;                // Misc device configuration
   reg  [1:0]  oc_s_r;                // Over-current synchroniser
   reg  [1:0]  uc_s_r;                // Under-current synchroniser
   reg  [9:0]  blank_cnt_r;           // Blanking countdown
   reg  [PW-1:0] on_cnt_r;            // Clocks since cycle start
   wire        qual_fault;
   wire [3:0]  run_cnt;

   // Blank time in clocks, rounded up so blanking is never short
   function [9:0] blank_clks;
      input [4:0] code;
      reg   [31:0] ns;
      reg   [31:0] clks;
      begin
         ns         = code * `CSCFG_BLANK_STEP_NS;
         clks       = (ns + `CSCFG_CLK_NS - 1) / `CSCFG_CLK_NS;
         blank_clks = clks[9:0];                  // At most 20 clocks, fits
      end
   endfunction

   // Minimum on time: period * 2(v+1)/512
   function [PW-1:0] min_clks;
      input [PW-1:0] per;
      input [4:0]    v;
      reg   [PW+6:0] prod;
      begin
         // Both operands at full product width so no high bit is lost
         prod     = {6'h00, per, 1'b0} * {{(PW+1){1'b0}}, ({1'b0, v} + 6'h01)};
         min_clks = {2'b00, prod[PW+6:9]};
      end
   endfunction

   assign rd_valid = (cmd_code == `CSCFG_CMD_ISENSE) | (cmd_code == `CSCFG_CMD_MISC);

   // ************************************************************
   // Register writes
   // ************************************************************
   always @(posedge clk) begin
      if (!rstn) begin
         isense_r <= `CSCFG_ISENSE_RST;
         misc_r   <= `CSCFG_MISC_RST;
      end else if (ce && wr_en) begin
         if (cmd_code == `CSCFG_CMD_ISENSE)
            isense_r <= wr_data;
         else if (cmd_code == `CSCFG_CMD_MISC)
            misc_r <= wr_data;
      end
   end

   // Read mux registered; unmapped codes read the run count
   always @(posedge clk) begin
      if (!rstn)
         rd_data <= 16'h0000;
      else if (ce) begin
         case (cmd_code)
            `CSCFG_CMD_ISENSE: rd_data <= isense_r;
            `CSCFG_CMD_MISC:   rd_data <= misc_r;
            default:           rd_data <= {12'h000, run_cnt};
         endcase
      end
   end

   // ************************************************************
   // Comparator synchronisers
   // ************************************************************
   always @(posedge clk) begin
      if (!rstn) begin
         oc_s_r <= 2'h0;
         uc_s_r <= 2'h0;
      end else if (ce) begin
         oc_s_r <= {oc_s_r[0], oc_pin};
         uc_s_r <= {uc_s_r[0], uc_pin};
      end
   end

   // ************************************************************
   // Blanking window
   // ************************************************************
   // Measurement closes on each transition unless the blank code is zero, and reopens after the blank
   always @(posedge clk) begin
      if (!rstn) begin
         blank_cnt_r <= 10'h000;
         meas_enable <= 1'b0;
      end else if (ce) begin
         if (edge_evt) begin
            blank_cnt_r <= blank_clks(isense_r[`CSCFG_BLANK_MSB:`CSCFG_BLANK_LSB]);
            meas_enable <= (isense_r[`CSCFG_BLANK_MSB:`CSCFG_BLANK_LSB] == 5'h00);
         end else if (blank_cnt_r > 10'h001) begin
            blank_cnt_r <= blank_cnt_r - 10'h001;
         end else begin
            blank_cnt_r <= 10'h000;
            meas_enable <= 1'b1;
         end
      end
   end

   // Only events inside the measurement window count
   cscfg_fault_qual #(.CW(4)) u_qual (
      .clk        (clk),
      .rstn       (rstn),
      .ce         (ce),
      .cyc_start  (cyc_start),
      .evt        (meas_enable & (oc_s_r[1] | uc_s_r[1])),
      .fault_code (isense_r[`CSCFG_FCNT_MSB:`CSCFG_FCNT_LSB]),
      .fault      (qual_fault),
      .run_count  (run_cnt)
   );

   // ************************************************************
   // Modulator clamp and drive gate
   // ************************************************************
   always @(posedge clk) begin
      if (!rstn)
         on_cnt_r <= {PW{1'b0}};
      else if (ce) begin
         if (cyc_start)
            on_cnt_r <= {PW{1'b0}};
         else if (on_cnt_r != {PW{1'b1}})
            on_cnt_r <= on_cnt_r + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   // Decoded outputs, all registered
   always @(posedge clk) begin
      if (!rstn) begin
         sense_on_falling_ripple <= 1'b0;
         sense_on_rising_ripple  <= 1'b0;
         adc_range_sel      <= `CSCFG_RANGE_25MV;
         min_on_clks        <= {PW{1'b0}};
         pwm_out            <= 1'b0;
         power_good_pin_o   <= 1'b0;
         power_good_pin_oe  <= 1'b1;
         ext_temp_comp_en   <= 1'b0;
         ext_temp_fault_sel <= 1'b0;
         current_fault      <= 1'b0;
      end else if (ce) begin
         sense_on_falling_ripple <= (isense_r[3:2] == `CSCFG_METH_FALL);
         sense_on_rising_ripple  <= (isense_r[3:2] == `CSCFG_METH_RISE);
         adc_range_sel <= isense_r[`CSCFG_RANGE_MSB:`CSCFG_RANGE_LSB];
         min_on_clks   <= min_clks(period_clks,
                                   misc_r[`CSCFG_MIND_MSB:`CSCFG_MIND_LSB]);
         // Drive off overrides clamp; clamp stretches short pulses
         if (!misc_r[`CSCFG_DRV_EN_BIT])
            pwm_out <= 1'b0;
         else if (misc_r[`CSCFG_MIND_EN_BIT] && (on_cnt_r < min_on_clks) && !cyc_start)
            pwm_out <= 1'b1;
         else
            pwm_out <= pwm_in;
         // Open-drain only pulls low; push-pull drives both levels
         power_good_pin_o  <= power_good_level & misc_r[`CSCFG_PGOOD_PP_BIT];
         power_good_pin_oe <= misc_r[`CSCFG_PGOOD_PP_BIT] | ~power_good_level;
         ext_temp_comp_en   <= misc_r[`CSCFG_EXT_COMP_BIT];
         ext_temp_fault_sel <= misc_r[`CSCFG_EXT_FLT_BIT];
         current_fault      <= qual_fault;
      end
   end
endmodule // cscfg_top

/* bench/cscfg_checker.sv */
// Concurrent checks on the configuration block ports
`timescale 1ns/100ps
module cscfg_checker (
   input logic        clk,
   input logic        rstn,
   input logic        ce,
   input logic [7:0]  cmd_code,
   input logic        wr_en,
   input logic [15:0] wr_data,
   input logic        rd_valid,
   input logic        power_good_level,
   input logic        cyc_start,
   input logic        sense_on_falling_ripple,
   input logic        sense_on_rising_ripple,
   input logic [1:0]  adc_range_sel,
   input logic        power_good_pin_oe,
   input logic        ext_temp_comp_en,
   input logic        ext_temp_fault_sel,
   input logic        current_fault
);
   // ************************************************************
   // Helpers
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [3:0] since_r;  // Clocks since a cycle start, saturating
   // Ties fault edges to cycle starts; saturates so long gaps never wrap
   always @(posedge clk) begin
      if (!rstn) since_r <= 4'hF;
      else if (cyc_start) since_r <= 4'h0;
      else if (since_r != 4'hF) since_r <= since_r + 4'h1;
   end
   // Write taken, then one enabled edge for the register to land
   sequence s_wr(logic [7:0] c);
      ce && wr_en && cmd_code == c ##1 ce;
   endsequence
   // ************************************************************
   // Decode checks
   // ************************************************************
   a_fall_slope: assert property (s_wr(8'hD0) |=>
      sense_on_falling_ripple == ($past(wr_data[3:2], 2) == 2'h1)) else $error("falling slope");
   a_rise_slope: assert property (s_wr(8'hD0) |=>
      sense_on_rising_ripple == ($past(wr_data[3:2], 2) == 2'h2)) else $error("rising slope");
   a_range_sel: assert property (s_wr(8'hD0) |=>
      adc_range_sel == $past(wr_data[1:0], 2)) else $error("range select");
   a_comp_enable: assert property (s_wr(8'hD1) |=>
      ext_temp_comp_en == $past(wr_data[1], 2)) else $error("compensation enable");
   a_fault_source: assert property (s_wr(8'hD1) |=>
      ext_temp_fault_sel == $past(wr_data[0], 2)) else $error("fault sensor select");
   a_power_good_style: assert property (s_wr(8'hD1) |=>
      power_good_pin_oe == ($past(wr_data[2], 2) || !$past(power_good_level)))
      else $error("power good style");
   a_map_valid: assert property (rd_valid == (cmd_code == 8'hD0 || cmd_code == 8'hD1))
      else $error("mapped flag");
   a_fault_rise: assert property ($rose(current_fault) |-> since_r <= 4'h4)
      else $error("fault raised away from a cycle start");
   a_fault_clear: assert property ($fell(current_fault) |-> since_r <= 4'h4)
      else $error("fault cleared away from a cycle start");
endmodule // cscfg_checker
bind cscfg_top cscfg_checker u_cscfg_checker (.clk, .rstn, .ce, .cmd_code, .wr_en, .wr_data,
   .rd_valid, .power_good_level, .cyc_start, .sense_on_falling_ripple, .sense_on_rising_ripple,
   .adc_range_sel, .power_good_pin_oe, .ext_temp_comp_en, .ext_temp_fault_sel, .current_fault);

/* bench/cscfg_host.sv */
// Management host model writing and reading configuration words
`timescale 1ns/100ps
module cscfg_host (
   input  logic        clk,
   input  logic [15:0] rd_data,
   output logic [7:0]  cmd_code,
   output logic        wr_en,
   output logic [15:0] wr_data
);
   // Idle bus at time zero
   initial begin
      cmd_code = 8'h00;
      wr_en = 1'b0;
      wr_data = 16'h0000;
   end
   // Whole word, one strobe cycle; released data inverted so nothing stale lingers
   task automatic put(input logic [7:0] c, input logic [15:0] d);
      @(negedge clk);
      cmd_code = c;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      wr_data = ~d;
   endtask
   // Select a word, then take it once the registered read path has caught up
   task automatic get(input logic [7:0] c, output logic [15:0] d);
      @(negedge clk);
      cmd_code = c;
      repeat (2) @(negedge clk);
      d = rd_data;
   endtask
endmodule // cscfg_host

/* bench/cscfg_top_test.sv */
// Self-checking bench for the current-sense and misc configuration block
`timescale 1ns/100ps
module cscfg_top_test;
   // ************************************************************
   // Signals and table
   // ************************************************************
   logic        clk, rstn, ce, wr_en, rd_valid, cyc_start, edge_evt, oc_pin, uc_pin;
   logic        pwm_in, meas_enable, sense_on_falling_ripple, sense_on_rising_ripple;
   logic        pwm_out, power_good_pin_o, power_good_pin_oe, ext_temp_comp_en;
   logic        ext_temp_fault_sel, current_fault, power_good_level;
   logic [1:0]  adc_range_sel;
   logic [7:0]  cmd_code;
   logic [15:0] wr_data, rd_data, period_clks, min_on_clks, got;
   int          n_errors, checked, i, k, n;
   wire  [7:0]  obs = {sense_on_falling_ripple, sense_on_rising_ripple, adc_range_sel,
                       ext_temp_comp_en, ext_temp_fault_sel, power_good_pin_oe, power_good_pin_o};
   typedef struct packed {logic [7:0] c; logic [15:0] d; logic [7:0] e;} cscfg_row_t;
   cscfg_row_t  rows [8] = '{'{8'hD0, 16'h0004, 8'h80}, '{8'hD0, 16'h0009, 8'h50},
      '{8'hD0, 16'h0002, 8'h20}, '{8'hD0, 16'h000C, 8'h00}, '{8'hD1, 16'h0405, 8'h07},
      '{8'hD1, 16'h0402, 8'h08}, '{8'hD2, 16'hFFFF, 8'h08}, '{8'hD1, 16'h0401, 8'h04}};
   int          blk [4] = '{0, 1, 25, 31};  // Blanking codes: both ends and between
   cscfg_top u_cscfg_top (.clk, .rstn, .ce, .cmd_code, .wr_en, .wr_data, .rd_data, .rd_valid,
      .period_clks, .cyc_start, .edge_evt, .oc_pin, .uc_pin, .power_good_level, .pwm_in,
      .meas_enable, .sense_on_falling_ripple, .sense_on_rising_ripple, .adc_range_sel,
      .min_on_clks, .pwm_out, .power_good_pin_o, .power_good_pin_oe, .ext_temp_comp_en,
      .ext_temp_fault_sel, .current_fault);
   cscfg_host u_cscfg_host (.clk, .rd_data, .cmd_code, .wr_en, .wr_data);
   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({15'h0000, g}, {15'h0000, e});
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic do_reset;
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
   endtask
   // Nine-clock period; two comparator pulses stress the once-per-cycle count
   task automatic period(input logic ev, input logic sel);
      for (int j = 0; j < 8; j++) begin
         @(negedge clk);
         oc_pin = ev && sel && (j == 1 || j == 2 || j == 4);
         uc_pin = ev && !sel && (j == 1 || j == 2 || j == 4);
         cyc_start = (j == 7);
      end
      @(negedge clk);
      cyc_start = 1'b0;
   endtask
   task automatic fchk(input logic e);
      repeat (3) @(negedge clk);
      chkb(current_fault, e);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {ce, power_good_level} = 2'h3;
      {rstn, cyc_start, edge_evt, oc_pin, uc_pin, pwm_in} = 6'h00;
      {n_errors, checked} = 0;
      period_clks = 16'h0200;
      do_reset();
      foreach (rows[r]) begin
         u_cscfg_host.put(rows[r].c, rows[r].d);
         u_cscfg_host.get(rows[r].c, got);
         chk({8'h00, obs}, {8'h00, rows[r].e});
         chkb(rd_valid, rows[r].c < 8'hD2);
         if (rows[r].c < 8'hD2) chk(got, rows[r].d);
      end
      power_good_level = 1'b0;
      repeat (3) @(negedge clk);
      chk({14'h0000, power_good_pin_oe, power_good_pin_o}, 16'h0002);
      pwm_in = 1'b1;
      for (i = 0; i < 2; i++) begin
         u_cscfg_host.put(8'hD1, {5'h00, !i[0], 10'h000});
         repeat (3) @(negedge clk);
         chkb(pwm_out, !i[0]);
      end
      pwm_in = 1'b0;
      for (n = 0; n < 32; n += 31) begin
         for (i = 0; i < 2; i++) begin
            u_cscfg_host.put(8'hD1, {n[4:0], 3'h4, i[0], 7'h00});
            repeat (3) @(negedge clk);
            chk(min_on_clks, 2 * (n[15:0] + 16'h0001));
            cyc_start = 1'b1;
            @(negedge clk);
            cyc_start = 1'b0;
            k = 0;
            repeat (80) begin
               k += pwm_out;
               @(negedge clk);
            end
            chk(k[15:0], i ? 2 * (n[15:0] + 16'h0001) : 16'h0000);
         end
      end
      foreach (blk[b]) begin
         u_cscfg_host.put(8'hD0, {blk[b][4:0], 11'h000});
         repeat (2) @(negedge clk);
         edge_evt = 1'b1;
         k = 0;
         repeat (30) begin
            @(negedge clk);
            edge_evt = 1'b0;
            k += !meas_enable;
         end
         chk(k[15:0], (blk[b][15:0] * 16'h0020 + 16'h0031) / 16'h0032);
      end
      for (n = 0; n < 8; n = 2 * n + 1) begin
         k = 2 * n + 1;
         u_cscfg_host.put(8'hD0, {5'h00, n[2:0], 8'h00});
         period(1'b0, 1'b0);
         repeat (k - 1) period(1'b1, n[0]);
         period(1'b0, 1'b0);
         fchk(1'b0);
         repeat (k - 1) period(1'b1, n[1]);
         // Unmapped code reads the run count: one per period despite repeated pulses
         u_cscfg_host.get(8'hD2, got);
         chk(got, k[15:0] - 16'h0001);
         fchk(1'b0);
         period(1'b1, n[1]);
         fchk(1'b1);
         period(1'b0, 1'b0);
         fchk(1'b0);
      end
      // Clock enable low: a write must be dropped and the word kept
      ce = 1'b0;
      u_cscfg_host.put(8'hD1, 16'h0000);
      repeat (2) @(negedge clk);
      ce = 1'b1;
      u_cscfg_host.get(8'hD1, got);
      chk(got, 16'hFC80);
      do_reset();
      u_cscfg_host.get(8'hD0, got);
      chk(got, 16'h0000);
      u_cscfg_host.get(8'hD1, got);
      chk(got, 16'h0400);
      close_out();
   end
endmodule // cscfg_top_test
